// *** logic/rsso_pkg.sv ***
/*
  Shared constants for the rotate, subtract and sleep execution block.
  Assumes nothing of its surroundings; referenced by scoped name from the watchdog and core modules.
*/
package rsso_pkg;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int NIB_W = 4;
  localparam int WDOG_W = 16;
  localparam int PRESC_W = 8;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [15:0] WDOG_ZERO = 16'h0000;
  localparam logic [7:0] PRESC_ZERO = 8'h00;
  localparam logic [7:0] PRESC_TERM = 8'hFF;
  localparam logic PD_RST = 1'b1;
  localparam logic TO_RST = 1'b1;
  localparam logic [1:0] OP_NONE = 2'h0;
  typedef enum logic [2:0] {
    RSSO_NOP,
    RSSO_RRF_OP,
    RSSO_SUBF_OP,
    RSSO_SUBL_OP,
    RSSO_SLEEP_OP
  } rsso_op_t;
endpackage

// *** logic/rsso_subtract.sv ***
/*
  Two's-complement subtractor with carry and digit-carry as inverse borrows.
  Assumes operands are stable in the cycle the result is used.
*/
`timescale 1ns/1ps
module rsso_subtract (
  input wire logic [7:0] minuend,
  input wire logic [7:0] subtrahend,
  output logic [7:0] diff,
  output logic carry_out,
  output logic nibble_carry_out,
  output logic zero_out
);
  logic [8:0] full;
  logic [4:0] low;

  // Carry is the inverse of a borrow, so the extra top bit holds the borrow and is inverted to give it.
  assign full = {1'b0, minuend} - {1'b0, subtrahend};
  assign low = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]};
  assign diff = full[7:0];
  assign carry_out = ~full[8];
  assign nibble_carry_out = ~low[4];
  assign zero_out = (full[7:0] == 8'h00);
endmodule

// *** logic/rsso_watchdog.sv ***
/*
  Watchdog prescaler and counter, cleared on a sleep request.
  Assumes a one-cycle tick enable from the core timebase.
*/
`timescale 1ns/1ps
module rsso_watchdog (
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic clear,
  output logic [15:0] count,
  output logic [7:0] presc
);
  logic [15:0] count_r;
  logic [7:0] presc_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      presc_r <= rsso_pkg::PRESC_ZERO;
    end else if (clear) begin
      presc_r <= rsso_pkg::PRESC_ZERO;
    end else if (tick) begin
      presc_r <= presc_r + 8'h01;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_r <= rsso_pkg::WDOG_ZERO;
    end else if (clear) begin
      count_r <= rsso_pkg::WDOG_ZERO;
    end else if (tick && presc_r == rsso_pkg::PRESC_TERM) begin
      count_r <= count_r + 16'h0001;
    end
  end

  assign count = count_r;
  assign presc = presc_r;
endmodule

// *** logic/rsso_core.sv ***
/*
  Execution of rotate-right-through-carry, both subtracts and sleep.
  Assumes the operand fetch presents the file value with a one-cycle op strobe.
*/
`timescale 1ns/1ps
// Behaviour
// - Rotate right through carry; only carry changes
// - Rotate destination: 0 accumulator, 1 file
// - Sleep clears power-down bit, sets time-out bit
// - Sleep zeroes watchdog counter and prescaler
// - File minus accumulator; carry, nibble carry, zero
// - Subtract destination: 0 accumulator, 1 file
// - Literal minus accumulator into accumulator, flags
module rsso_core (
  input wire logic clk,
  input wire logic rst,
  input wire logic op_valid,
  input wire rsso_pkg::rsso_op_t op_code,
  input wire logic [6:0] file_addr,
  input wire logic [7:0] file_data,
  input wire logic [7:0] literal,
  input wire logic dest_sel,
  input wire logic wdog_tick,
  output logic [7:0] acc,
  output logic carry_flag,
  output logic nibble_borrow_inverse_flag,
  output logic zero_flag,
  output logic powerdown_flag_n,
  output logic expiry_flag_n,
  output logic file_we,
  output logic [6:0] file_wr_addr,
  output logic [7:0] file_wr_data,
  output logic sleep_req,
  output logic [15:0] watchdog_counter,
  output logic [7:0] watchdog_presc
);
  // ----------------------------------------
  // Datapath
  // ----------------------------------------
  logic [7:0] sub_min;
  logic [7:0] sub_diff;
  logic sub_c;
  logic sub_dc;
  logic sub_z;
  logic [7:0] rot_val;
  logic is_rrf;
  logic is_subf;
  logic is_subl;
  logic is_sleep;

  logic [7:0] acc_r;
  logic carry_r;
  logic dc_r;
  logic zero_r;
  logic pd_n_r;
  logic to_n_r;
  logic file_we_r;
  logic [6:0] file_wr_addr_r;
  logic [7:0] file_wr_data_r;
  logic sleep_req_r;

  assign is_rrf = op_valid && op_code == rsso_pkg::RSSO_RRF_OP;
  assign is_subf = op_valid && op_code == rsso_pkg::RSSO_SUBF_OP;
  assign is_subl = op_valid && op_code == rsso_pkg::RSSO_SUBL_OP;
  assign is_sleep = op_valid && op_code == rsso_pkg::RSSO_SLEEP_OP;

  assign rot_val = {carry_r, file_data[7:1]};
  assign sub_min = is_subl ? literal : file_data;

  rsso_subtract u_sub (
    .minuend(sub_min),
    .subtrahend(acc_r),
    .diff(sub_diff),
    .carry_out(sub_c),
    .nibble_carry_out(sub_dc),
    .zero_out(sub_z)
  );

  rsso_watchdog u_wdog (
    .clk(clk),
    .rst(rst),
    .tick(wdog_tick),
    .clear(is_sleep),
    .count(watchdog_counter),
    .presc(watchdog_presc)
  );

  // ----------------------------------------
  // Accumulator
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_r <= rsso_pkg::ACC_RST;
    end else if (is_rrf && !dest_sel) begin
      acc_r <= rot_val;
    end else if (is_subf && !dest_sel) begin
      acc_r <= sub_diff;
    end else if (is_subl) begin
      acc_r <= sub_diff;
    end
  end

  // ----------------------------------------
  // Arithmetic flags
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      carry_r <= 1'b0;
    end else if (is_rrf) begin
      carry_r <= file_data[0];
    end else if (is_subf || is_subl) begin
      carry_r <= sub_c;
    end
  end

  // Nibble carry and zero are left alone by rotate and sleep.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dc_r <= 1'b0;
      zero_r <= 1'b0;
    end else if (is_subf || is_subl) begin
      dc_r <= sub_dc;
      zero_r <= sub_z;
    end
  end

  // ----------------------------------------
  // Power status
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pd_n_r <= rsso_pkg::PD_RST;
      to_n_r <= rsso_pkg::TO_RST;
    end else if (is_sleep) begin
      pd_n_r <= 1'b0;
      to_n_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // File write-back
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      file_we_r <= 1'b0;
      file_wr_addr_r <= 7'h00;
      file_wr_data_r <= 8'h00;
    end else begin
      file_we_r <= (is_rrf || is_subf) && dest_sel;
      if ((is_rrf || is_subf) && dest_sel) begin
        file_wr_addr_r <= file_addr;
        file_wr_data_r <= is_rrf ? rot_val : sub_diff;
      end
    end
  end

  // A registered sleep request reaches the wake-up logic on the same edge that updates the power-down and time-out flags.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sleep_req_r <= 1'b0;
    end else begin
      sleep_req_r <= is_sleep;
    end
  end

  assign acc = acc_r;
  assign carry_flag = carry_r;
  assign nibble_borrow_inverse_flag = dc_r;
  assign zero_flag = zero_r;
  assign powerdown_flag_n = pd_n_r;
  assign expiry_flag_n = to_n_r;
  assign file_we = file_we_r;
  assign file_wr_addr = file_wr_addr_r;
  assign file_wr_data = file_wr_data_r;
  assign sleep_req = sleep_req_r;
endmodule

// *** bench/rsso_core_sva.sv ***
/* Port checker for rsso_core.
   Assumes a bind to each rsso_core instance. */
`timescale 1ns/1ps
module rsso_core_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic op_valid,
  input wire rsso_pkg::rsso_op_t op_code,
  input wire logic [7:0] file_data,
  input wire logic [7:0] literal,
  input wire logic dest_sel,
  input wire logic [7:0] acc,
  input wire logic carry_flag,
  input wire logic nibble_borrow_inverse_flag,
  input wire logic zero_flag,
  input wire logic powerdown_flag_n,
  input wire logic expiry_flag_n,
  input wire logic file_we,
  input wire logic [7:0] file_wr_data,
  input wire logic sleep_req,
  input wire logic [15:0] watchdog_counter,
  input wire logic [7:0] watchdog_presc
);
  // ----------------------------------------
  // Expected results
  // ----------------------------------------
  wire logic rotate_right_carry_op = op_valid && op_code == rsso_pkg::RSSO_RRF_OP;
  wire logic subf = op_valid && op_code == rsso_pkg::RSSO_SUBF_OP;
  wire logic subl = op_valid && op_code == rsso_pkg::RSSO_SUBL_OP;
  wire logic slp = op_valid && op_code == rsso_pkg::RSSO_SLEEP_OP;
  // Rotation through carry is the nine-bit word carry then file value.
  wire logic [8:0] rot = {carry_flag, file_data};
  wire logic [9:0] exp_f = {file_data - acc, acc <= file_data, acc[3:0] <= file_data[3:0]};
  wire logic [9:0] exp_l = {literal - acc, acc <= literal, acc[3:0] <= literal[3:0]};
  wire logic zf = subl ? literal == acc : file_data == acc;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_RRF_ACC: assert property (rotate_right_carry_op && !dest_sel |=> {acc, carry_flag} == $past(rot) && $stable(zero_flag))
    else $error("rotate into accumulator wrong");
  AST_RRF_FILE: assert property (rotate_right_carry_op && dest_sel |=> file_we && {file_wr_data, carry_flag} == $past(rot) && $stable(acc))
    else $error("rotate into file wrong");
  AST_SLEEP_FLAGS: assert property (slp |=> !powerdown_flag_n && expiry_flag_n && sleep_req && $stable(carry_flag))
    else $error("sleep status wrong");
  AST_SLEEP_WDOG: assert property (slp |=> watchdog_counter == 16'h0000 && watchdog_presc == 8'h00)
    else $error("sleep watchdog not cleared");
  AST_SUBF_ACC: assert property (subf && !dest_sel |=> {acc, carry_flag, nibble_borrow_inverse_flag} == $past(exp_f))
    else $error("file subtract wrong");
  AST_SUBF_FILE: assert property (subf && dest_sel |=> file_we && file_wr_data == $past(exp_f) >> 2 && $stable(acc))
    else $error("file subtract destination wrong");
  AST_SUBL: assert property (subl |=> {acc, carry_flag, nibble_borrow_inverse_flag} == $past(exp_l))
    else $error("literal subtract wrong");
  AST_ZERO: assert property (subf || subl |=> zero_flag == $past(zf))
    else $error("zero flag wrong");
  AST_NO_WRITE: assert property (!((rotate_right_carry_op || subf) && dest_sel) |=> !file_we)
    else $error("file write without a file destination");
  AST_SLEEP_PULSE: assert property (!slp |=> !sleep_req)
    else $error("sleep request without sleep");
  cover property (rotate_right_carry_op ##1 rotate_right_carry_op);
  cover property (slp);
  cover property (subf && dest_sel);
endmodule
bind rsso_core rsso_core_sva u_chk (.*);

// *** bench/tb_top.sv ***
/* Self-checking bench for rsso_core.
   Assumes the package and design files are compiled first. */
`timescale 1ns/1ps
module tb_top;
  typedef struct {rsso_pkg::rsso_op_t o; logic d; logic [7:0] f, k, a; logic [3:0] g; logic [7:0] q;} rsso_row_t;
  localparam rsso_pkg::rsso_op_t op_rr = rsso_pkg::RSSO_RRF_OP;
  localparam rsso_pkg::rsso_op_t op_sf = rsso_pkg::RSSO_SUBF_OP;
  localparam rsso_pkg::rsso_op_t op_sl = rsso_pkg::RSSO_SUBL_OP;
  logic clk = 1'h0, rst = 1'h1, op_valid = 1'h0, dest_sel = 1'h0, wdog_tick = 1'h0;
  rsso_pkg::rsso_op_t op_code = rsso_pkg::RSSO_NOP;
  logic [6:0] file_addr = 7'h2A;
  logic [7:0] file_data = 8'h00, literal = 8'h00;
  logic [7:0] acc, file_wr_data, watchdog_presc;
  logic carry_flag, nibble_borrow_inverse_flag, zero_flag, powerdown_flag_n, expiry_flag_n, file_we, sleep_req;
  logic [6:0] file_wr_addr;
  logic [15:0] watchdog_counter;
  int error_cnt = 0, comparisons = 0;
  rsso_row_t r;
  // Flags column g is carry, nibble carry, zero, file write.
  rsso_row_t rows [12] = '{
    '{op_sl, 1'h0, 8'h00, 8'h05, 8'h05, 4'hC, 8'h00}, '{op_sf, 1'h0, 8'h05, 8'h00, 8'h00, 4'hE, 8'h00},
    '{op_sl, 1'h0, 8'h00, 8'h12, 8'h12, 4'hC, 8'h00}, '{op_sf, 1'h0, 8'h20, 8'h00, 8'h0E, 4'h8, 8'h00},
    '{op_sl, 1'h0, 8'h00, 8'h0D, 8'hFF, 4'h0, 8'h00}, '{op_rr, 1'h0, 8'h81, 8'h00, 8'h40, 4'h8, 8'h00},
    '{op_rr, 1'h0, 8'h02, 8'h00, 8'h81, 4'h0, 8'h00}, '{op_sf, 1'h1, 8'h85, 8'h00, 8'h81, 4'hD, 8'h04},
    '{op_rr, 1'h1, 8'h01, 8'h00, 8'h81, 4'hD, 8'h80}, '{rsso_pkg::RSSO_NOP, 1'h1, 8'hFF, 8'h00, 8'h81, 4'hC, 8'h00},
    '{op_sl, 1'h0, 8'h00, 8'h81, 8'h00, 4'hE, 8'h00}, '{rsso_pkg::RSSO_SLEEP_OP, 1'h0, 8'h00, 8'h00, 8'h00, 4'hE, 8'h00}};
  rsso_core DUT (.*);
  // ----------------------------------------
  // Clock, compare and verdict
  // ----------------------------------------
  always #10 clk = ~clk;
  task automatic chk(input string n, input logic [23:0] s, input logic [23:0] e);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wrap_up;
    if (error_cnt == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    chk("reset", {acc, carry_flag, nibble_borrow_inverse_flag, zero_flag, powerdown_flag_n, expiry_flag_n, file_we, sleep_req}, 24'h00000C);
    rst <= 1'h0;
    wdog_tick <= 1'h1;
    // Operations run back to back so each one sees the previous result.
    for (int i = 0; i <= 12; i++) begin
      @(posedge clk);
      op_valid <= i < 12;
      op_code <= rows[i % 12].o;
      dest_sel <= rows[i % 12].d;
      file_data <= rows[i % 12].f;
      literal <= rows[i % 12].k;
      #1;
      if (i > 0) begin
        r = rows[i - 1];
        chk("acc", acc, r.a);
        chk("flags", {carry_flag, nibble_borrow_inverse_flag, zero_flag, file_we}, r.g);
        if (r.g[0]) chk("wdata", file_wr_data, r.q);
        if (r.g[0]) chk("waddr", file_wr_addr, 7'h2A);
      end
    end
    chk("sleep", {powerdown_flag_n, expiry_flag_n, sleep_req}, 24'h000003);
    chk("wdog", {watchdog_counter, watchdog_presc}, 24'h000000);
    @(posedge clk);
    rst <= 1'h1;
    #1;
    chk("reset2", {acc, carry_flag, nibble_borrow_inverse_flag, zero_flag, powerdown_flag_n, expiry_flag_n, file_we, sleep_req}, 24'h00000C);
    @(posedge clk);
    rst <= 1'h0;
    op_valid <= 1'h1;
    op_code <= op_sl;
    literal <= 8'h01;
    @(posedge clk);
    op_valid <= 1'h0;
    #1;
    chk("first", {acc, carry_flag, nibble_borrow_inverse_flag, zero_flag}, 24'h00000E);
    // Let the prescaler wrap so the counter is non-zero before sleep clears it.
    repeat (300) @(posedge clk);
    chk("wdog_run", {8'h00, watchdog_counter != 16'h0000}, 24'h000001);
    op_valid <= 1'h1;
    op_code <= rsso_pkg::RSSO_SLEEP_OP;
    @(posedge clk);
    op_valid <= 1'h0;
    #1;
    chk("wdog2", {watchdog_counter, watchdog_presc}, 24'h000000);
    wrap_up();
  end
endmodule
